// >>> shared/conv_ctrl_defines.svh
`ifndef CONV_CTRL_DEFINES_SVH
`define CONV_CTRL_DEFINES_SVH

// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define CCW_ADC_RATE_BIT    0
`define CCW_CLK_SEL_BIT     1
`define CCW_START_BIT       3
`define CCW_DONE_BIT        4
`define CCW_ADC_EN_BIT      5
`define CCW_PORT_LO_BIT     6
`define CCW_PORT_HI_BIT     7
`define CCW_PWM_RATE_BIT    8
`define CCW_ONE_BIT         9
`define CCW_INT0_SEL_BIT    15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCW_RST_START       1'b1
`define CCW_RST_ADC_EN      1'b0
`define CCW_RST_OTHER       1'b0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ             25
`define PERIOD_10K_NS       100000
`define PERIOD_16K_NS       62500
`define ACTIVE_NUM          4
`define ACTIVE_DEN          5
`define AUTOZERO_NS         400
`define CONVERT_NS          1600
`define PERIOD_10K_CYC      ((`CLK_MHZ * `PERIOD_10K_NS) / 1000)
`define PERIOD_16K_CYC      ((`CLK_MHZ * `PERIOD_16K_NS) / 1000)
`define ACTIVE_16K_CYC      ((`PERIOD_16K_CYC * `ACTIVE_NUM) / `ACTIVE_DEN)
`define AUTOZERO_CYC        ((`CLK_MHZ * `AUTOZERO_NS + 999) / 1000)
`define CONVERT_CYC         ((`CLK_MHZ * `CONVERT_NS) / 1000)

`endif

// >>> shared/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

    typedef struct packed {
        logic       int0_sel;
        logic       pwm_rate_10k;
        logic [1:0] dsp_port;
        logic       adc_en;
        logic       start;
        logic       clk_sel;
        logic       adc_rate_16k;
    } ctrl_t;

    typedef enum logic [2:0] {
        ADC_IDLE     = 3'b001,
        ADC_AUTOZERO = 3'b010,
        ADC_CONVERT  = 3'b100
    } adc_state_t;

endpackage

// >>> hw/pwm_slot_gen.sv
`timescale 1ns/10ps
`default_nettype none

module pwm_slot_gen
    import conv_ctrl_pkg::*;
#(
    parameter int GW = 5
) (
    input  wire logic [2*GW-1:0] slot_i,
    input  wire logic [2*GW-1:0] sample_i,
    output logic                 level_o
);
    logic [GW-1:0] group;
    logic [GW-1:0] pos;
    logic [GW-1:0] level_fld;
    logic [GW-1:0] spread_fld;

    always_comb begin
        group      = slot_i[2*GW-1:GW];
        pos        = slot_i[GW-1:0];
        level_fld  = sample_i[2*GW-1:GW];
        spread_fld = sample_i[GW-1:0];
        if (pos == '0) begin
            level_o = (group < spread_fld);
        end else begin
            level_o = (pos <= level_fld);
        end
    end
endmodule // pwm_slot_gen

`default_nettype wire

// >>> hw/conv_ctrl.sv
// How it works
// - Control bit 8 picks 10 or 16 kHz
// - 16 kHz: high only in first four fifths
// - 10 kHz: active region spans whole period
// - Active region holds 1024 equal slots
// - Sample splits into level and spread fields
// - Slots form 32 groups of 32
// - Spread sets first slots, level the rest
// - Auto-zero precedes each 8-bit conversion
// - Sample tick at 10 or 16 kHz
// - Conversion finishes within 2 microseconds
// - Start command accepted at any moment while enable bit set
// - Start during conversion restarts it
// - New settings apply next clock; PWM rate from next period
// - Enable bit powers converter on or off
// - Done flag set; data read clears it
// - Start bit zero: convert on each tick while enable bit set
// - Result in bits 9:2, bits 1:0 zero
// - Reset clears converter enable bit
`include "conv_ctrl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int SLOT_BITS = 10,
    parameter int ADC_BITS  = 8
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic                 ctrl_wr_i,
    input  wire logic [15:0]          ctrl_wdata_i,
    input  wire logic                 data_wr_i,
    input  wire logic [15:0]          data_wdata_i,
    input  wire logic                 data_rd_i,
    input  wire logic [ADC_BITS-1:0]  adc_code_i,
    output logic [15:0]               ctrl_rdata_o,
    output logic [15:0]               data_rdata_o,
    output logic                      pwm_o,
    output logic                      output_tick_o,
    output logic                      sample_tick_o,
    output logic                      adc_power_o,
    output logic                      adc_autozero_o,
    output logic                      adc_convert_o,
    output logic [1:0]                dsp_port_o
);
    localparam int SLOTS = 1 << SLOT_BITS;
    localparam logic [11:0] P10K = 12'(`PERIOD_10K_CYC);
    localparam logic [11:0] P16K = 12'(`PERIOD_16K_CYC);
    localparam logic [11:0] A16K = 12'(`ACTIVE_16K_CYC);
    localparam logic [5:0]  AZ_CYC = 6'(`AUTOZERO_CYC);
    localparam logic [5:0]  CV_CYC = 6'(`CONVERT_CYC);

    function automatic logic [11:0] period_of(input logic sel_10k);
        period_of = sel_10k ? P10K : P16K;
    endfunction

    // ----------------------------------------
    // Control word
    // ----------------------------------------
    ctrl_t ctrl_q, ctrl_d;
    logic  start_cmd;

    always_comb begin
        ctrl_d    = ctrl_q;
        start_cmd = 1'b0;
        if (ctrl_wr_i) begin
            ctrl_d.int0_sel     = ctrl_wdata_i[`CCW_INT0_SEL_BIT];
            ctrl_d.pwm_rate_10k = ctrl_wdata_i[`CCW_PWM_RATE_BIT];
            ctrl_d.dsp_port     = ctrl_wdata_i[`CCW_PORT_HI_BIT:`CCW_PORT_LO_BIT];
            ctrl_d.adc_en       = ctrl_wdata_i[`CCW_ADC_EN_BIT];
            ctrl_d.start        = ctrl_wdata_i[`CCW_START_BIT];
            ctrl_d.clk_sel      = ctrl_wdata_i[`CCW_CLK_SEL_BIT];
            ctrl_d.adc_rate_16k = ctrl_wdata_i[`CCW_ADC_RATE_BIT];
            start_cmd           = ctrl_wdata_i[`CCW_START_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_q              <= '0;
            ctrl_q.adc_en       <= `CCW_RST_ADC_EN;
            ctrl_q.start        <= `CCW_RST_START;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ----------------------------------------
    // PWM output timing
    // ----------------------------------------
    // Fractional slot stepping: clock is not a multiple of slot rate
    logic [11:0]          pcnt_q, pcnt_d;
    logic [11:0]          acc_q, acc_d;
    logic [SLOT_BITS:0]   slot_q, slot_d;
    logic [SLOT_BITS-1:0] sample_q, sample_d;
    logic [SLOT_BITS-1:0] live_q, live_d;
    logic                 pwm_q, pwm_d;
    logic                 otick_q, otick_d;
    logic                 cur10k_q, cur10k_d;
    logic                 slot_hi;
    logic [11:0]          active_len;
    logic [12:0]          acc_sum;

    pwm_slot_gen #(
        .GW (SLOT_BITS / 2)
    ) u_slot (
        .slot_i   (slot_q[SLOT_BITS-1:0]),
        .sample_i (live_q),
        .level_o  (slot_hi)
    );

    always_comb begin
        pcnt_d     = pcnt_q + 12'h0001;
        acc_d      = acc_q;
        slot_d     = slot_q;
        sample_d   = sample_q;
        live_d     = live_q;
        cur10k_d   = cur10k_q;
        otick_d    = 1'b0;
        active_len = cur10k_q ? P10K : A16K;
        acc_sum    = {1'b0, acc_q} + 13'(SLOTS);
        if (data_wr_i) begin
            sample_d = data_wdata_i[SLOT_BITS-1:0];
        end
        if (pcnt_q == period_of(cur10k_q) - 12'h0001) begin
            pcnt_d   = '0;
            acc_d    = '0;
            slot_d   = '0;
            live_d   = sample_d;
            cur10k_d = ctrl_q.pwm_rate_10k;
            otick_d  = 1'b1;
        end else if (!slot_q[SLOT_BITS]) begin
            // Equal slot widths within one cycle of jitter
            if (acc_sum >= {1'b0, active_len}) begin
                acc_d  = 12'(acc_sum - {1'b0, active_len});
                slot_d = slot_q + {{SLOT_BITS{1'b0}}, 1'b1};
            end else begin
                acc_d  = acc_sum[11:0];
            end
        end
        pwm_d = !slot_q[SLOT_BITS] && slot_hi;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pcnt_q   <= '0;
            acc_q    <= '0;
            slot_q   <= '0;
            sample_q <= '0;
            live_q   <= '0;
            pwm_q    <= 1'b0;
            otick_q  <= 1'b0;
            cur10k_q <= 1'b0;
        end else if (ce_i) begin
            pcnt_q   <= pcnt_d;
            acc_q    <= acc_d;
            slot_q   <= slot_d;
            sample_q <= sample_d;
            live_q   <= live_d;
            pwm_q    <= pwm_d;
            otick_q  <= otick_d;
            cur10k_q <= cur10k_d;
        end
    end

    // ----------------------------------------
    // Sample tick timer
    // ----------------------------------------
    logic [11:0] tcnt_q, tcnt_d;
    logic        stick_q, stick_d;

    always_comb begin
        tcnt_d  = tcnt_q + 12'h0001;
        stick_d = 1'b0;
        if (tcnt_q >= period_of(!ctrl_q.adc_rate_16k) - 12'h0001) begin
            tcnt_d  = '0;
            stick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tcnt_q  <= '0;
            stick_q <= 1'b0;
        end else if (ce_i) begin
            tcnt_q  <= tcnt_d;
            stick_q <= stick_d;
        end
    end

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    adc_state_t          st_q, st_d;
    logic [5:0]          cyc_q, cyc_d;
    logic                done_q, done_d;
    logic [ADC_BITS-1:0] res_q, res_d;
    logic                pwr_q, pwr_d;
    logic [15:0]         crd_q, crd_d;
    logic [15:0]         drd_q, drd_d;
    logic                go;

    always_comb begin
        st_d  = st_q;
        cyc_d = cyc_q + 6'h01;
        res_d = res_q;
        go    = start_cmd || (stick_q && !ctrl_q.start);
        done_d = done_q && !data_rd_i;
        if (go && ctrl_d.adc_en) begin
            // Abort and restart from auto-zero with cycle count cleared
            st_d  = ADC_AUTOZERO;
            cyc_d = '0;
        end else begin
            case (st_q)
                ADC_IDLE: begin
                    cyc_d = '0;
                end
                ADC_AUTOZERO: begin
                    if (cyc_q == AZ_CYC - 6'h01) begin
                        st_d  = ADC_CONVERT;
                        cyc_d = '0;
                    end
                end
                ADC_CONVERT: begin
                    if (cyc_q == CV_CYC - 6'h01) begin
                        st_d   = ADC_IDLE;
                        res_d  = adc_code_i;
                        done_d = 1'b1;
                    end
                end
                default: begin
                    st_d = ADC_IDLE;
                end
            endcase
        end
        // Disable waits for a running conversion to finish
        pwr_d = ctrl_d.adc_en || (st_d != ADC_IDLE);
        crd_d = '0;
        crd_d[`CCW_INT0_SEL_BIT] = ctrl_q.int0_sel;
        crd_d[`CCW_ONE_BIT]      = 1'b1;
        crd_d[`CCW_PWM_RATE_BIT] = ctrl_q.pwm_rate_10k;
        crd_d[`CCW_PORT_HI_BIT:`CCW_PORT_LO_BIT] = ctrl_q.dsp_port;
        crd_d[`CCW_ADC_EN_BIT]   = ctrl_q.adc_en;
        crd_d[`CCW_DONE_BIT]     = done_q;
        crd_d[`CCW_START_BIT]    = ctrl_q.start;
        crd_d[`CCW_CLK_SEL_BIT]  = ctrl_q.clk_sel;
        crd_d[`CCW_ADC_RATE_BIT] = ctrl_q.adc_rate_16k;
        drd_d = {6'h00, res_q, 2'b00};
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q   <= ADC_IDLE;
            cyc_q  <= '0;
            done_q <= 1'b0;
            res_q  <= '0;
            pwr_q  <= 1'b0;
            crd_q  <= 16'h0208;
            drd_q  <= '0;
        end else if (ce_i) begin
            st_q   <= st_d;
            cyc_q  <= cyc_d;
            done_q <= done_d;
            res_q  <= res_d;
            pwr_q  <= pwr_d;
            crd_q  <= crd_d;
            drd_q  <= drd_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb begin
        ctrl_rdata_o   = crd_q;
        data_rdata_o   = drd_q;
        pwm_o          = pwm_q;
        output_tick_o  = otick_q;
        sample_tick_o  = stick_q;
        adc_power_o    = pwr_q;
        adc_autozero_o = st_q[1];
        adc_convert_o  = st_q[2];
        dsp_port_o     = ctrl_q.dsp_port;
    end
endmodule // conv_ctrl

`default_nettype wire

// >>> testbench/adc_front_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Comparator front end
// ----
module adc_front_model (
    input  wire logic       clk_sys_i,
    input  wire logic       convert_i,
    input  wire logic [7:0] level_i,
    output logic      [7:0] code_o
);
    // Churns between 5a and a5 outside conversion so a late sample looks right only for those levels
    logic [7:0] junk_q = 8'h5a;
    always_ff @(posedge clk_sys_i) junk_q <= ~junk_q;
    assign code_o = convert_i ? level_i : junk_q;
endmodule // adc_front_model
`default_nettype wire

// >>> testbench/conv_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module conv_ctrl_props
    import conv_ctrl_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        ctrl_wr_i,
    input wire logic [15:0] ctrl_wdata_i,
    input wire logic        data_rd_i,
    input wire logic [15:0] ctrl_rdata_o,
    input wire logic        pwm_o,
    input wire logic        output_tick_o,
    input wire logic        sample_tick_o,
    input wire logic        adc_power_o,
    input wire logic        adc_autozero_o,
    input wire logic        adc_convert_o
);
    // ----
    // Period counters
    // ----
    logic [11:0] pc_q, pc_d, sc_q, sc_d;
    logic        pv_q, pv_d, sv_q, sv_d, m10_q, m10_d, r16_q, r16_d;
    always_comb begin
        pc_d  = output_tick_o ? 12'h001 : pc_q + 12'h001;
        sc_d  = sample_tick_o ? 12'h001 : sc_q + 12'h001;
        pv_d  = pv_q | output_tick_o;
        sv_d  = sv_q | sample_tick_o;
        m10_d = output_tick_o ? ctrl_rdata_o[8] : m10_q;
        r16_d = sample_tick_o ? ctrl_rdata_o[0] : r16_q;
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {pc_q, sc_q, pv_q, sv_q, m10_q, r16_q} <= '0;
        end else if (ce_i) begin
            // Frozen cycles do not count, as in the design's own timers
            {pc_q, sc_q, pv_q, sv_q, m10_q, r16_q} <= {pc_d, sc_d, pv_d, sv_d, m10_d, r16_d};
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence zero_s; adc_autozero_o [*8] ##2 adc_autozero_o; endsequence
    sequence conv_s; adc_convert_o [*8] ##32 adc_convert_o; endsequence
    // Restarts cut a phase short, so they switch these two off
    zero_first_a: assert property (
        disable iff (rst_i || ctrl_wr_i && ctrl_wdata_i[3] || sample_tick_o)
        $rose(adc_autozero_o) |-> zero_s ##1 (adc_convert_o && !adc_autozero_o))
        else $error("auto-zero not ten cycles");
    conv_len_a: assert property (
        disable iff (rst_i || ctrl_wr_i && ctrl_wdata_i[3] || sample_tick_o)
        $rose(adc_convert_o) |-> conv_s ##1 !adc_convert_o)
        else $error("conversion not forty cycles");
    start_any_a: assert property (ce_i && ctrl_wr_i && ctrl_wdata_i[3] && ctrl_wdata_i[5]
        |=> adc_autozero_o && !adc_convert_o) else $error("start ignored");
    reset_off_a: assert property (disable iff (1'b0) rst_i ##1 rst_i
        |=> ctrl_rdata_o == 16'h0208 && !adc_power_o) else $error("bad reset state");
    done_set_a: assert property ($fell(adc_convert_o) && !adc_autozero_o
        |-> ##1 ctrl_rdata_o[4]) else $error("done not set");
    done_clr_a: assert property (data_rd_i && ce_i && !adc_convert_o && !$past(adc_convert_o)
        |-> ##2 !ctrl_rdata_o[4]) else $error("done not cleared");
    auto_tick_a: assert property (sample_tick_o && ctrl_rdata_o[5] && !ctrl_rdata_o[3]
        && !adc_autozero_o && !adc_convert_o && !ctrl_wr_i && !$past(ctrl_wr_i)
        && !$past(ctrl_wr_i, 2) |-> ##[1:2] adc_autozero_o) else $error("tick did not start");
    pwm_rate_a: assert property (output_tick_o && pv_q && ctrl_rdata_o[8] == m10_q
        |-> pc_q == (m10_q ? 12'h9c4 : 12'h61a)) else $error("pwm period wrong");
    adc_rate_a: assert property (sample_tick_o && sv_q && ctrl_rdata_o[0] == r16_q
        |-> sc_q == (r16_q ? 12'h61a : 12'h9c4)) else $error("sample period wrong");
    low_tail_a: assert property (pv_q && !m10_q && !ctrl_rdata_o[8] && pc_q >= 12'h4e3
        |-> !pwm_o) else $error("pwm high outside active region");
endmodule // conv_ctrl_props
bind conv_ctrl conv_ctrl_props conv_ctrl_props_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .data_rd_i(data_rd_i), .ctrl_rdata_o(ctrl_rdata_o),
    .pwm_o(pwm_o), .output_tick_o(output_tick_o), .sample_tick_o(sample_tick_o),
    .adc_power_o(adc_power_o), .adc_autozero_o(adc_autozero_o), .adc_convert_o(adc_convert_o)
);
`default_nettype wire

// >>> testbench/test_conv_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_conv_ctrl;
    logic        clk_sys_i, rst_i, ce_i, ctrl_wr_i, data_wr_i, data_rd_i;
    logic [15:0] ctrl_wdata_i, data_wdata_i, ctrl_rdata, data_rdata, v;
    logic [7:0]  level, code;
    logic        pwm, otick, stick, power, az, cv;
    logic [1:0]  dport;
    logic [10:0] cases [6] = '{11'h53a, 11'h13a, 11'h7ff, 11'h001, 11'h400, 11'h3e0};
    int          failures, checked, na, nc;

    conv_ctrl conv_ctrl_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .ctrl_wr_i(ctrl_wr_i),
        .ctrl_wdata_i(ctrl_wdata_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
        .data_rd_i(data_rd_i), .adc_code_i(code), .ctrl_rdata_o(ctrl_rdata),
        .data_rdata_o(data_rdata), .pwm_o(pwm), .output_tick_o(otick), .sample_tick_o(stick),
        .adc_power_o(power), .adc_autozero_o(az), .adc_convert_o(cv), .dsp_port_o(dport)
    );
    adc_front_model adc_front_model_inst (
        .clk_sys_i(clk_sys_i), .convert_i(cv), .level_i(level), .code_o(code)
    );
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ----
    // Access tasks
    // ----
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Kind 0 control write, 1 sample write, 2 data read
    task automatic strobe(input int k, input logic [15:0] d);
        @(posedge clk_sys_i);
        ctrl_wr_i    <= (k == 0);
        data_wr_i    <= (k == 1);
        data_rd_i    <= (k == 2);
        ctrl_wdata_i <= d;
        data_wdata_i <= d;
        @(posedge clk_sys_i);
        {ctrl_wr_i, data_wr_i, data_rd_i} <= 3'b000;
        v = data_rdata;
    endtask
    task automatic wait_done(output int a, output int c);
        int i;
        a = 0;
        c = 0;
        for (i = 0; i < 400 && ctrl_rdata[4] !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            a += int'(az);
            c += int'(cv);
        end
        if (ctrl_rdata[4] !== 1'b1) begin
            failures++;
            test_done;
        end
    endtask
    task automatic gap(input logic o, output int n);
        int i;
        for (i = 0; i < 3000 && (o ? otick : stick) !== 1'b1; i++) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        for (n = 1; n < 3000 && (o ? otick : stick) !== 1'b1; n++) @(posedge clk_sys_i);
        if (n >= 3000) begin
            failures++;
            test_done;
        end
    endtask
    task automatic pwm_try(input logic r10, input logic [9:0] s);
        int p, a, n, last, i, ls;
        p  = r10 ? 2500 : 1562;
        a  = r10 ? 2500 : 1249;
        ls = (s[9:5] != 5'h00) ? 993 + int'(s[9:5]) : 32 * int'(s[4:0]) - 31;
        if (ls < 0) ls = 0;
        strobe(0, {7'h00, r10, 8'h00});
        strobe(1, {6'h00, s});
        gap(1'b1, n);
        gap(1'b1, n);
        chk("pwm period", 16'(n), 16'(p));
        n = 0;
        last = 0;
        for (i = 1; i <= p; i++) begin
            @(posedge clk_sys_i);
            if (pwm === 1'b1) begin
                n++;
                last = i;
            end
        end
        i = n - (int'(s[4:0]) + 32 * int'(s[9:5])) * a / 1024;
        chk("pwm highs", 16'(i >= -3 && i <= 3), 16'h0001);
        i = last - ls * a / 1024;
        chk("pwm last", 16'(i >= -4 && i <= 4), 16'h0001);
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        {rst_i, ce_i} = 2'b11;
        {ctrl_wr_i, data_wr_i, data_rd_i} = 3'b000;
        ctrl_wdata_i = 16'h0000;
        data_wdata_i = 16'h0000;
        level = 8'h00;
        failures = 0;
        checked = 0;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        chk("ctrl reset", ctrl_rdata, 16'h0208);
        chk("power reset", 16'(power), 16'h0000);
        level <= 8'ha5;
        strobe(0, 16'h0028);
        wait_done(na, nc);
        chk("autozero len", 16'(na), 16'h000a);
        chk("convert len", 16'(nc), 16'h0028);
        strobe(2, 16'h0000);
        chk("adc result", v, 16'h0294);
        repeat (2) @(posedge clk_sys_i);
        chk("done cleared", 16'(ctrl_rdata[4]), 16'h0000);
        // A start and port write while frozen must leave no trace
        ce_i <= 1'b0;
        strobe(0, 16'h00e8);
        ce_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk("frozen port", 16'(dport), 16'h0000);
        chk("frozen start", 16'(az), 16'h0000);
        level <= 8'h3c;
        strobe(0, 16'h0028);
        repeat (20) @(posedge clk_sys_i);
        strobe(0, 16'h7cc5);
        repeat (2) @(posedge clk_sys_i);
        chk("ctrl readback", ctrl_rdata, 16'h02c1);
        wait_done(na, nc);
        strobe(2, 16'h0000);
        chk("kept result", v, 16'h00f0);
        chk("dsp port", 16'(dport), 16'h0003);
        repeat (3) @(posedge clk_sys_i);
        chk("power off", 16'(power), 16'h0000);
        strobe(0, 16'h0008);
        repeat (3) @(posedge clk_sys_i);
        chk("start refused", 16'(az), 16'h0000);
        level <= 8'h11;
        strobe(0, 16'h0028);
        repeat (20) @(posedge clk_sys_i);
        level <= 8'h7e;
        strobe(0, 16'h0028);
        wait_done(na, nc);
        chk("restart zero", 16'(na), 16'h000a);
        strobe(2, 16'h0000);
        chk("restart result", v, 16'h01f8);
        strobe(0, 16'h0021);
        gap(1'b0, na);
        gap(1'b0, na);
        chk("tick 16k", 16'(na), 16'h061a);
        repeat (2) @(posedge clk_sys_i);
        chk("auto start", 16'(az), 16'h0001);
        strobe(0, 16'h0020);
        gap(1'b0, na);
        gap(1'b0, na);
        chk("tick 10k", 16'(na), 16'h09c4);
        for (int k = 0; k < 6; k++) pwm_try(cases[k][10], cases[k][9:0]);
        test_done;
    end
endmodule // test_conv_ctrl
`default_nettype wire
